// ===== include/fpdr_pkg.sv
/*
  shared constants for the focal plane digital readout: widths, control
  word fields, register offsets, reset values and the gain mode type.
  assumes a single core clock; all pins are sampled as synchronous inputs.
*/
package fpdr_pkg;

  // ****************************************
  // sizes
  // ****************************************
  localparam int NCH   = 32;
  localparam int CHW   = 5;
  localparam int CNTW  = 14;
  localparam int OFFW  = 12;
  localparam int WORDW = 16;
  localparam int BITW  = 4;
  localparam int GAINW = 8;
  localparam int GSELW = 3;
  localparam int CTLW  = 16;
  localparam int ROW   = CHW + BITW;

  // ****************************************
  // control word fields
  // ****************************************
  localparam int CTL_GAIN_CHG  = 0;
  localparam int CTL_CAL_STEP  = 1;
  localparam int CTL_GAIN_INIT = 2;
  localparam int CTL_HOLD_RST  = 3;
  localparam int CTL_OFF_LOAD  = 9;

  // ****************************************
  // reset values and counts
  // ****************************************
  localparam logic [CNTW-1:0]  CNT_RST    = 14'h0000;
  localparam logic [CTLW-1:0]  CTL_RST    = 16'h0000;
  localparam logic [WORDW-1:0] THRESH_RST = 16'h0000;
  localparam logic [BITW-1:0]  GAIN_FIRST = 4'h1;
  localparam logic [BITW-1:0]  GAIN_LAST  = 4'h8;
  localparam logic [GSELW-1:0] GSEL_MAX   = 3'h7;

  // ****************************************
  // register byte offsets
  // ****************************************
  localparam logic [11:0] ADDR_THRESH = 12'h000;
  localparam logic [11:0] ADDR_CTRL   = 12'h004;
  localparam logic [11:0] ADDR_STATUS = 12'h008;

  typedef enum logic [1:0] {GM_IDLE, GM_INIT, GM_CAL} fpdr_gmode_e;

  function automatic logic [CNTW-1:0] fpdr_gray_to_bin(input logic [CNTW-1:0] g);
    logic [CNTW-1:0] b;
    b[CNTW-1] = g[CNTW-1];
    for (int k = CNTW - 2; k >= 0; k--) begin
      b[k] = b[k+1] ^ g[k];
    end
    return b;
  endfunction

endpackage

// ===== src/fpdr_apb_regs.sv
/*
  apb slave holding the threshold word and reading back control and status.
  assumes apb signals synchronous to core_clk; zero wait states.
*/
`timescale 1ns/10ps
module fpdr_apb_regs
  import fpdr_pkg::*;
(
  input  wire logic              core_clk,   // clock
  input  wire logic              rst_n,      // sync reset
  input  wire logic              psel,       // apb select
  input  wire logic              penable,    // apb enable
  input  wire logic              pwrite,     // apb write
  input  wire logic [11:0]       paddr,      // apb address
  input  wire logic [31:0]       pwdata,     // apb write data
  output logic      [31:0]       prdata,     // apb read data
  output logic                   pready,     // apb ready
  output logic                   pslverr,    // apb error
  input  wire logic [CTLW-1:0]   ctl_word,   // applied control word
  input  wire logic [15:0]       status_in,  // live status
  output logic      [WORDW-1:0]  thresh_reg  // threshold word
);
  import fpdr_pkg::*;

  logic mapped;
  logic access;

  assign access = psel & penable;
  assign mapped = (paddr == ADDR_THRESH) | (paddr == ADDR_CTRL) | (paddr == ADDR_STATUS);
  assign pready = 1'b1;
  // only the threshold word is writable
  assign pslverr = access & (~mapped | (pwrite & (paddr != ADDR_THRESH)));

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      thresh_reg <= THRESH_RST;
    end else if (access && pwrite && paddr == ADDR_THRESH) begin
      thresh_reg <= pwdata[WORDW-1:0];
    end
  end

  // read data captured in the setup cycle so it is a flop at the access edge
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        ADDR_THRESH: prdata <= {16'h0000, thresh_reg};
        ADDR_CTRL:   prdata <= {16'h0000, ctl_word};
        ADDR_STATUS: prdata <= {16'h0000, status_in};
        default:     prdata <= 32'h00000000;
      endcase
    end
  end

endmodule // fpdr_apb_regs

// ===== src/fpdr_gain_ctl.sv
/*
  gain capacitor latch sequencer: initialisation and successive
  approximation calibration, one channel word at a time.
  assumes bit ticks and frame sync are single-cycle strobes on core_clk.
*/
`timescale 1ns/10ps
module fpdr_gain_ctl
  import fpdr_pkg::*;
(
  input  wire logic             core_clk,    // clock
  input  wire logic             rst_n,       // sync reset
  input  wire logic             frame_sync,  // frame strobe
  input  wire logic             bit_tick,    // serial bit clock strobe
  input  wire logic [BITW-1:0]  ro_bit,      // bit slot in word
  input  wire logic [CHW-1:0]   ro_chan,     // addressed channel
  input  wire logic             sign_in,     // sign of current word
  input  wire logic             gain_change_enable, // latch write enable
  input  wire logic             cal_step,    // calibration step
  input  wire logic             gain_init_flag, // initialise gains
  output logic                  gain_latch_data, // latch value
  output logic                  gain_latch_we,   // latch write pulse
  output logic      [GSELW-1:0] gain_latch_bit,  // latch index, 0 = msb
  output logic      [CHW-1:0]   gain_latch_chan, // latch channel
  output logic      [GSELW-1:0] bit_sel_reg      // sar bit select
);
  import fpdr_pkg::*;

  fpdr_gmode_e     mode;
  logic            in_slot;
  logic [GSELW-1:0] idx;
  logic [GSELW-1:0] sel_next;
  logic            we_next;
  logic            data_next;

  always_comb begin
    if (!gain_change_enable) begin
      mode = GM_IDLE;
    end else if (gain_init_flag) begin
      mode = GM_INIT;
    end else if (cal_step) begin
      mode = GM_CAL;
    end else begin
      mode = GM_IDLE;
    end
  end

  // slots 1..8 address the latches; slot 0 is left for the sign to settle
  assign in_slot = (ro_bit >= GAIN_FIRST) && (ro_bit <= GAIN_LAST);
  assign idx = 3'(ro_bit - GAIN_FIRST);
  assign sel_next = bit_sel_reg + 3'h1;

  always_comb begin
    we_next = 1'b0;
    data_next = 1'b0;
    case (mode)
      GM_INIT: begin
        we_next = in_slot;
        data_next = (idx == 3'h0);
      end
      GM_CAL: begin
        if (in_slot && idx == bit_sel_reg) begin
          we_next = 1'b1;
          data_next = sign_in;
        end else if (in_slot && bit_sel_reg != GSEL_MAX && idx == sel_next) begin
          we_next = 1'b1;
          data_next = 1'b1;
        end
      end
      default: begin
        we_next = 1'b0;
        data_next = 1'b0;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      gain_latch_we <= 1'b0;
      gain_latch_data <= 1'b0;
      gain_latch_bit <= 3'h0;
      gain_latch_chan <= 5'h00;
    end else begin
      gain_latch_we <= bit_tick & we_next;
      gain_latch_data <= data_next;
      gain_latch_bit <= idx;
      gain_latch_chan <= ro_chan;
    end
  end

  // select advances once per calibration frame, cleared by initialisation
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      bit_sel_reg <= 3'h0;
    end else if (frame_sync && gain_init_flag) begin
      bit_sel_reg <= 3'h0;
    end else if (frame_sync && cal_step && bit_sel_reg != GSEL_MAX) begin
      bit_sel_reg <= sel_next;
    end
  end

endmodule // fpdr_gain_ctl

// ===== src/fpdr_readout.sv
/*
  digital section of a 32-channel focal plane readout: shared conversion
  counter, per-channel capture memories, offset and threshold correction,
  serial output, serial control word and gain calibration control.
  assumes every pin is synchronous to core_clk; frame_sync, count_tick,
  serial_bit_clock and ctrl_shift_en are single-cycle strobes.

  // Operation
  // - counter feeds memories; trip freezes channel memory
  // - counter restarts on the ramp start pulse
  // - conversion counter counts downward
  // - data registers load buffers at frame end
  // - offsets load from data in same transfer
  // - bit clock steps 32 channels, 16 bits each
  // - first adder: data minus stored offset
  // - second adder subtracts the threshold word
  // - result shifted out as 16-bit two's complement
  // - threshold is global, full scale capable
  // - offset holds 12 bits, lsb forced zero
  // - control bit 9 enables offset load
  // - control bit 3 holds counter in reset
  // - gain flags via serial port; sign compares
  // - gain timing from frame sync and bit clock
  // - gain init sets midrange, clears selector
  // - init: 8 of 16 clocks, one then zeros
  // - calibration latch value comes from sign
  // - step with frame sync advances bit selector
  // - sar: set selected bit, next bit one
  // - gray encode capture, decode before adder
  // - buffer and data registers are 14 bits
*/
`timescale 1ns/10ps
module fpdr_readout
  import fpdr_pkg::*;
(
  input  wire logic              core_clk,          // 10 MHz clock
  input  wire logic              rst_n,             // sync reset
  input  wire logic              psel,              // apb select
  input  wire logic              penable,           // apb enable
  input  wire logic              pwrite,            // apb write
  input  wire logic [11:0]       paddr,             // apb address
  input  wire logic [31:0]       pwdata,            // apb write data
  output logic      [31:0]       prdata,            // apb read data
  output logic                   pready,            // apb ready
  output logic                   pslverr,           // apb error
  input  wire logic [NCH-1:0]    comparator_trip,   // per-channel comparator
  input  wire logic              count_tick,        // master clock strobe
  input  wire logic              frame_sync,        // frame / ramp start
  input  wire logic              serial_bit_clock,  // output bit strobe
  input  wire logic              ctrl_shift_en,     // control bit strobe
  input  wire logic              ctrl_serial_in,    // control bit
  output logic                   serial_data_out,   // output bit
  output logic                   output_sign_result, // sign of word
  output logic                   data_reg_latch,    // data transfer pulse
  output logic                   offset_reg_latch,  // offset transfer pulse
  output logic                   gain_latch_data,   // gain latch value
  output logic                   gain_latch_we,     // gain latch write
  output logic      [GSELW-1:0]  gain_latch_bit,    // gain latch index
  output logic      [CHW-1:0]    gain_latch_chan    // gain latch channel
);
  import fpdr_pkg::*;

  // ****************************************
  // declarations
  // ****************************************
  logic [CNTW-1:0]  cnt_reg;
  logic [CNTW-1:0]  cnt_gray;
  logic [CNTW-1:0]  buf_mem  [NCH];
  logic [CNTW-1:0]  data_mem [NCH];
  logic [OFFW-1:0]  off_mem  [NCH];
  logic [CTLW-1:0]  ctl_shift_reg;
  logic [CTLW-1:0]  ctl_reg;
  logic [ROW-1:0]   ro_cnt_reg;
  logic [CHW-1:0]   ro_chan;
  logic [BITW-1:0]  ro_bit;
  logic [WORDW-1:0] shift_reg;
  logic [WORDW-1:0] thresh_reg;
  logic [CNTW-1:0]  data_bin;
  logic [WORDW-1:0] off_neg;
  logic [WORDW-1:0] thr_neg;
  logic [WORDW-1:0] corr_word;
  logic [WORDW-1:0] result_word;
  logic [GSELW-1:0] bit_sel_reg;
  logic [15:0]      status_word;
  logic             hold_counter_reset;
  logic             offset_load_enable;
  logic             gain_change_enable;
  logic             cal_step;
  logic             gain_init_flag;

  // ****************************************
  // control word
  // ****************************************
  assign hold_counter_reset = ctl_reg[CTL_HOLD_RST];
  assign offset_load_enable = ctl_reg[CTL_OFF_LOAD];
  assign gain_change_enable = ctl_reg[CTL_GAIN_CHG];
  assign cal_step           = ctl_reg[CTL_CAL_STEP];
  assign gain_init_flag     = ctl_reg[CTL_GAIN_INIT];

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ctl_shift_reg <= CTL_RST;
    end else if (ctrl_shift_en) begin
      ctl_shift_reg <= {ctl_shift_reg[CTLW-2:0], ctrl_serial_in};
    end
  end

  // a shifted word waits for frame sync so modes never change mid-frame
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ctl_reg <= CTL_RST;
    end else if (frame_sync) begin
      ctl_reg <= ctl_shift_reg;
    end
  end

  // ****************************************
  // conversion counter
  // ****************************************
  // restarts from zero and wraps downward, so the first tick
  // of the ramp already shows full scale
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cnt_reg <= CNT_RST;
    end else if (hold_counter_reset) begin
      cnt_reg <= CNT_RST;
    end else if (frame_sync) begin
      cnt_reg <= CNT_RST;
    end else if (count_tick) begin
      cnt_reg <= cnt_reg - 14'h0001;
    end
  end

  // gray code keeps a capture taken mid-transition within one count
  assign cnt_gray = cnt_reg ^ (cnt_reg >> 1);

  // ****************************************
  // per-channel buffer, data and offset
  // ****************************************
  assign data_reg_latch   = frame_sync;
  assign offset_reg_latch = frame_sync & offset_load_enable;

  genvar gi;
  generate
    for (gi = 0; gi < NCH; gi++) begin : g_chan
      logic [CNTW-1:0] buf_bin;

      assign buf_bin = fpdr_gray_to_bin(buf_mem[gi]);

      always_ff @(posedge core_clk) begin
        if (!rst_n) begin
          buf_mem[gi] <= CNT_RST;
        end else if (!comparator_trip[gi]) begin
          buf_mem[gi] <= cnt_gray;
        end
      end

      always_ff @(posedge core_clk) begin
        if (!rst_n) begin
          data_mem[gi] <= CNT_RST;
        end else if (data_reg_latch) begin
          data_mem[gi] <= buf_mem[gi];
        end
      end

      // offset follows the data register in the same transfer, so it
      // takes the buffer value that the data register is taking now
      always_ff @(posedge core_clk) begin
        if (!rst_n) begin
          off_mem[gi] <= 12'h000;
        end else if (offset_reg_latch) begin
          off_mem[gi] <= {buf_bin[OFFW-1:1], 1'b0};
        end
      end
    end
  endgenerate

  // ****************************************
  // output multiplexer address
  // ****************************************
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ro_cnt_reg <= 9'h000;
    end else if (frame_sync) begin
      ro_cnt_reg <= 9'h000;
    end else if (serial_bit_clock) begin
      ro_cnt_reg <= ro_cnt_reg + 9'h001;
    end
  end

  assign ro_chan = ro_cnt_reg[ROW-1:BITW];
  assign ro_bit  = ro_cnt_reg[BITW-1:0];

  // ****************************************
  // offset and threshold correction
  // ****************************************
  assign data_bin    = fpdr_gray_to_bin(data_mem[ro_chan]);
  assign off_neg     = ~{4'h0, off_mem[ro_chan]} + 16'h0001;
  assign corr_word   = {2'b00, data_bin} + off_neg;
  assign thr_neg     = ~thresh_reg + 16'h0001;
  assign result_word = corr_word + thr_neg;

  // ****************************************
  // serial output
  // ****************************************
  // the word loads on the first bit slot and its msb leaves on that slot
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      shift_reg <= 16'h0000;
    end else if (serial_bit_clock && !frame_sync) begin
      if (ro_bit == 4'h0) begin
        shift_reg <= result_word;
      end else begin
        shift_reg <= {shift_reg[WORDW-2:0], 1'b0};
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      output_sign_result <= 1'b0;
    end else if (serial_bit_clock && !frame_sync && ro_bit == 4'h0) begin
      output_sign_result <= result_word[WORDW-1];
    end
  end

  assign serial_data_out = shift_reg[WORDW-1];

  // ****************************************
  // gain calibration control
  // ****************************************
  fpdr_gain_ctl u_gain (
    .core_clk           (core_clk),
    .rst_n              (rst_n),
    .frame_sync         (frame_sync),
    .bit_tick           (serial_bit_clock & ~frame_sync),
    .ro_bit             (ro_bit),
    .ro_chan            (ro_chan),
    .sign_in            (output_sign_result),
    .gain_change_enable (gain_change_enable),
    .cal_step           (cal_step),
    .gain_init_flag     (gain_init_flag),
    .gain_latch_data    (gain_latch_data),
    .gain_latch_we      (gain_latch_we),
    .gain_latch_bit     (gain_latch_bit),
    .gain_latch_chan    (gain_latch_chan),
    .bit_sel_reg        (bit_sel_reg)
  );

  // ****************************************
  // register bus
  // ****************************************
  assign status_word = {4'h0, bit_sel_reg, ro_cnt_reg};

  fpdr_apb_regs u_regs (
    .core_clk   (core_clk),
    .rst_n      (rst_n),
    .psel       (psel),
    .penable    (penable),
    .pwrite     (pwrite),
    .paddr      (paddr),
    .pwdata     (pwdata),
    .prdata     (prdata),
    .pready     (pready),
    .pslverr    (pslverr),
    .ctl_word   (ctl_reg),
    .status_in  (status_word),
    .thresh_reg (thresh_reg)
  );

endmodule // fpdr_readout

// ===== test/fpdr_readout_assertions.sv
/*
  port checks for fpdr_readout, bound into every instance.
  assumes one core_clk domain with sync active-low rst_n.
*/
`timescale 1ns/10ps
module fpdr_readout_chk
  import fpdr_pkg::*;
(
  input wire logic        core_clk,           // clock
  input wire logic        rst_n,              // sync reset
  input wire logic        psel,               // apb select
  input wire logic        penable,            // apb enable
  input wire logic        pwrite,             // apb write
  input wire logic [11:0] paddr,              // apb address
  input wire logic [31:0] pwdata,             // apb wdata
  input wire logic [31:0] prdata,             // apb rdata
  input wire logic        pready,             // apb ready
  input wire logic        pslverr,            // apb error
  input wire logic        frame_sync,         // frame strobe
  input wire logic        serial_bit_clock,   // bit strobe
  input wire logic        serial_data_out,    // output bit
  input wire logic        output_sign_result, // word sign
  input wire logic        data_reg_latch,     // data pulse
  input wire logic        offset_reg_latch,   // offset pulse
  input wire logic        gain_latch_we       // gain write
);
  // *****
  // shadow of the threshold word
  // *****
  logic [WORDW-1:0] thr_reg;
  logic             acc;
  assign acc = psel && penable;
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      thr_reg <= THRESH_RST;
    end else if (acc && pwrite && paddr == ADDR_THRESH) begin
      thr_reg <= pwdata[WORDW-1:0];
    end
  end
  // *****
  // properties
  // *****
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  data_latch_a: assert property (data_reg_latch == frame_sync)
    else $error("data latch pulse off frame sync");
  offset_pair_a: assert property (offset_reg_latch |-> data_reg_latch && frame_sync)
    else $error("offset latch without data latch");
  bus_ready_a: assert property (acc |-> pready)
    else $error("access not ready");
  ro_write_a: assert property (acc && pwrite && (paddr == ADDR_CTRL || paddr == ADDR_STATUS) |-> pslverr)
    else $error("read-only write accepted");
  unmapped_a: assert property (acc && !pwrite && paddr > ADDR_STATUS |-> pslverr && prdata == 32'h00000000)
    else $error("unmapped read not refused");
  thresh_read_a: assert property (acc && !pwrite && paddr == ADDR_THRESH |-> prdata == {16'h0000, thr_reg})
    else $error("threshold readback wrong");
  out_hold_a: assert property (!serial_bit_clock |=> $stable(serial_data_out))
    else $error("output bit moved without bit clock");
  sign_hold_a: assert property (!serial_bit_clock |=> $stable(output_sign_result))
    else $error("sign moved without bit clock");
  gain_tick_a: assert property (gain_latch_we |-> $past(serial_bit_clock))
    else $error("gain write not after bit clock");
  cover property (offset_reg_latch);
  cover property (gain_latch_we);
  cover property (acc && pslverr);
endmodule // fpdr_readout_chk

bind fpdr_readout fpdr_readout_chk fpdr_readout_chk_inst (.core_clk, .rst_n, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .pslverr, .frame_sync, .serial_bit_clock, .serial_data_out, .output_sign_result,
  .data_reg_latch, .offset_reg_latch, .gain_latch_we);

// ===== test/fpdr_ctl_model.sv
/*
  off-chip controller model: frame sync, master ticks, bit clocks,
  control word port and comparator trips. assumes core_clk edges.
*/
`timescale 1ns/10ps
module fpdr_ctl_model
  import fpdr_pkg::*;
(
  input  wire logic           core_clk,         // clock
  input  wire logic           serial_data_out,  // output bit
  output logic                count_tick,       // master tick
  output logic                frame_sync,       // frame strobe
  output logic                serial_bit_clock, // bit strobe
  output logic                ctrl_shift_en,    // control strobe
  output logic                ctrl_serial_in,   // control bit
  output logic      [NCH-1:0] comparator_trip   // trips
);
  // *****
  // strobes: one cycle wide, always followed by a gap
  // *****
  initial begin
    {count_tick, frame_sync, serial_bit_clock, ctrl_shift_en, ctrl_serial_in} = 5'h00;
    comparator_trip = {NCH{1'b1}};
  end
  task automatic fsync();
    @(posedge core_clk) frame_sync <= 1'b1;
    @(posedge core_clk) frame_sync <= 1'b0;
  endtask
  task automatic count(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge core_clk) count_tick <= 1'b1;
      @(posedge core_clk) count_tick <= 1'b0;
    end
  endtask
  task automatic trip(input logic [NCH-1:0] m);
    @(posedge core_clk) comparator_trip <= m;
  endtask
  task automatic send_ctrl(input logic [CTLW-1:0] c);
    for (int i = CTLW - 1; i >= 0; i--) begin
      @(posedge core_clk) begin
        ctrl_shift_en  <= 1'b1;
        ctrl_serial_in <= c[i];
      end
      @(posedge core_clk) begin
        ctrl_shift_en  <= 1'b0;
        ctrl_serial_in <= ~c[i]; // no stale bit once released
      end
    end
  endtask
  task automatic word(output logic [WORDW-1:0] w);
    for (int i = WORDW - 1; i >= 0; i--) begin
      @(posedge core_clk) serial_bit_clock <= 1'b1;
      @(posedge core_clk) serial_bit_clock <= 1'b0;
      #1 w[i] = serial_data_out;
    end
  endtask
endmodule // fpdr_ctl_model

// ===== test/testbench.sv
/*
  self-checking bench for fpdr_readout: apb tasks, controller model, scenarios.
  assumes the 10 MHz core clock and sync active-low reset.
*/
`timescale 1ns/10ps
module testbench;
  import fpdr_pkg::*;
  logic             core_clk, rst_n, psel, penable, pwrite, pready, pslverr, er;
  logic [11:0]      paddr;
  logic [31:0]      pwdata, prdata, rd;
  logic             serial_data_out, output_sign_result, data_reg_latch, offset_reg_latch;
  logic             gain_latch_data, gain_latch_we;
  logic             count_tick, frame_sync, serial_bit_clock, ctrl_shift_en, ctrl_serial_in;
  logic [NCH-1:0]   comparator_trip;
  logic [GSELW-1:0] gain_latch_bit;
  logic [CHW-1:0]   gain_latch_chan;
  logic [WORDW-1:0] w;
  logic [7:0]       gmask, gdat;
  int               err_count = 0;
  int               checked = 0;
  int               wcnt = 0;

  fpdr_readout fpdr_readout_inst (.core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .comparator_trip(comparator_trip), .count_tick(count_tick), .frame_sync(frame_sync),
    .serial_bit_clock(serial_bit_clock), .ctrl_shift_en(ctrl_shift_en), .ctrl_serial_in(ctrl_serial_in),
    .serial_data_out(serial_data_out), .output_sign_result(output_sign_result),
    .data_reg_latch(data_reg_latch), .offset_reg_latch(offset_reg_latch), .gain_latch_data(gain_latch_data),
    .gain_latch_we(gain_latch_we), .gain_latch_bit(gain_latch_bit), .gain_latch_chan(gain_latch_chan));
  fpdr_ctl_model fpdr_ctl_model_inst (.core_clk(core_clk), .serial_data_out(serial_data_out),
    .count_tick(count_tick), .frame_sync(frame_sync), .serial_bit_clock(serial_bit_clock),
    .ctrl_shift_en(ctrl_shift_en), .ctrl_serial_in(ctrl_serial_in), .comparator_trip(comparator_trip));

  initial core_clk = 1'b0;
  always #50 core_clk = ~core_clk;

  // *****
  // tasks
  // *****
  task automatic end_sim();
    $display("checked %0d err_count %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge core_clk) begin
      psel   <= 1'b1;
      pwrite <= wr;
      paddr  <= a;
      pwdata <= d;
    end
    @(posedge core_clk) penable <= 1'b1;
    for (n = 0; n < 16; n++) begin
      @(posedge core_clk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n == 16) begin
      err_count++;
      $display("mismatch at %0t: no pready", $time);
      end_sim();
    end
  endtask
  task automatic clrg();
    wcnt  = 0;
    gmask = 8'h00;
    gdat  = 8'h00;
  endtask

  // gain latch writes of the word being shifted; index 0 lands in the msb
  always @(posedge core_clk) begin
    if (gain_latch_we === 1'b1) begin
      wcnt++;
      gmask[7 - gain_latch_bit] = 1'b1;
      gdat[7 - gain_latch_bit]  = gain_latch_data;
      chk({27'h0, gain_latch_chan}, 32'h0);
    end
  end

  initial begin
    repeat (20000) @(posedge core_clk);
    err_count++;
    $display("mismatch at %0t: timeout", $time);
    end_sim();
  end

  // *****
  // scenarios
  // *****
  initial begin
    rst_n   = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h0;
    clrg();
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    apb(1'b0, ADDR_THRESH, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, ADDR_THRESH, 32'h0000FFFF);
    apb(1'b0, ADDR_THRESH, 32'h0);
    chk(rd, 32'h0000FFFF);
    apb(1'b1, ADDR_CTRL, 32'h0000FFFF);
    chk({31'h0, er}, 32'h1);
    apb(1'b0, 12'h010, 32'h0);
    chk({31'h0, er}, 32'h1);
    chk(rd, 32'h0);
    apb(1'b1, ADDR_THRESH, 32'h00000010);
    $display("done registers");
    fpdr_ctl_model_inst.trip(32'h0);
    fpdr_ctl_model_inst.fsync();
    fpdr_ctl_model_inst.count(5);
    fpdr_ctl_model_inst.trip(32'h00000001);
    fpdr_ctl_model_inst.count(3);
    fpdr_ctl_model_inst.trip(32'hFFFFFFFF);
    fpdr_ctl_model_inst.fsync();
    fpdr_ctl_model_inst.word(w);
    chk({16'h0, w}, 32'h3FEB);
    fpdr_ctl_model_inst.word(w);
    chk({16'h0, w}, 32'h3FE8);
    $display("done conversion");
    fpdr_ctl_model_inst.send_ctrl(16'h0200);
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk(rd, 32'h0);
    fpdr_ctl_model_inst.trip(32'h0);
    fpdr_ctl_model_inst.fsync();
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk(rd, 32'h0200);
    fpdr_ctl_model_inst.count(2);
    fpdr_ctl_model_inst.trip(32'hFFFFFFFF);
    fpdr_ctl_model_inst.fsync();
    fpdr_ctl_model_inst.word(w);
    chk({16'h0, w}, 32'h2FF0);
    $display("done offset");
    fpdr_ctl_model_inst.send_ctrl(16'h0208);
    fpdr_ctl_model_inst.fsync();
    fpdr_ctl_model_inst.trip(32'h0);
    fpdr_ctl_model_inst.count(4);
    fpdr_ctl_model_inst.trip(32'hFFFFFFFF);
    fpdr_ctl_model_inst.fsync();
    fpdr_ctl_model_inst.word(w);
    chk({16'h0, w}, 32'hFFF0);
    chk({31'h0, output_sign_result}, 32'h1);
    $display("done hold");
    fpdr_ctl_model_inst.send_ctrl(16'h0005);
    fpdr_ctl_model_inst.fsync();
    clrg();
    fpdr_ctl_model_inst.word(w);
    chk(wcnt, 8);
    chk({gmask, gdat}, 32'hFF80);
    $display("done gain init");
    fpdr_ctl_model_inst.send_ctrl(16'h0003);
    fpdr_ctl_model_inst.fsync();
    fpdr_ctl_model_inst.fsync();
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(rd, 32'h0200);
    clrg();
    fpdr_ctl_model_inst.word(w);
    chk(wcnt, 2);
    chk({gmask, gdat}, 32'h6060);
    $display("done gain cal");
    end_sim();
  end
endmodule // testbench
